// ---- sim/tb.sv ----
`timescale 1ns/1ps
module tb
  import irq_ctrl_pkg::*;
;
  logic mclk = 1'h0;
  logic rst_b = 1'h0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wrData = 8'h00;
  logic wrStb = 1'h0;
  logic rdStb = 1'h0;
  logic [2:0] evt = 3'h0;
  logic rfiPulse = 1'h0;
  logic [7:0] rdData_q;
  logic coreIrq_q;
  logic irq_q;
  int failures = 0;
  int comparisons = 0;

  always #2.5 mclk = ~mclk;

  interrupt_enable_flag_register uut (
    .mclk(mclk),
    .rst_b(rst_b),
    .addr(addr),
    .wrData(wrData),
    .wrStb(wrStb),
    .rdStb(rdStb),
    .rdData_q(rdData_q),
    .timerOverflow(evt[2]),
    .extPinEdge(evt[1]),
    .portChange(evt[0]),
    .returnFromInterrupt(rfiPulse),
    .coreIrq_q(coreIrq_q),
    .irq_q(irq_q)
  );

  // ---------------------------------------------
  // Bus and check tasks
  // ---------------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      failures++;
      $display("unexpected at %0t: got %h want %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic r);
    @(posedge mclk);
    addr <= a;
    wrData <= d;
    wrStb <= 1'h1;
    rfiPulse <= r;
    @(posedge mclk);
    wrStb <= 1'h0;
    rfiPulse <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    addr <= a;
    rdStb <= 1'h1;
    @(posedge mclk);
    rdStb <= 1'h0;
    #1;
    check(rdData_q, exp);
  endtask : rd

  task automatic pulse(input logic [2:0] e);
    @(posedge mclk);
    evt <= e;
    @(posedge mclk);
    evt <= 3'h0;
  endtask : pulse

  // The core request lags the state by one register; the event request is registered from the next state and does not lag
  task automatic irqs(input logic c, input logic i);
    repeat (2) @(posedge mclk);
    #1;
    check({7'h00, coreIrq_q}, {7'h00, c});
    check({7'h00, irq_q}, {7'h00, i});
  endtask : irqs

  task automatic end_of_test;
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask : end_of_test

  // ---------------------------------------------
  // Main sequence
  // ---------------------------------------------
  initial
  begin
    repeat (6) @(posedge mclk);
    rst_b <= 1'h1;
    rd(ADDR_CTRL_BANK0, CTRL_RESET);
    rd(ADDR_IRQ_STATUS, 8'h00);
    wr(ADDR_CTRL_BANK0, 8'hFF, 1'h0);
    rd(ADDR_CTRL_BANK1, 8'hFF & WRITABLE_MASK);
    irqs(1'h1, 1'h0);
    wr(ADDR_CTRL_BANK1, 8'h00, 1'h0);
    pulse(3'h7);
    rd(ADDR_CTRL_BANK0, 8'h07);
    irqs(1'h0, 1'h0);
    wr(ADDR_CTRL_BANK0, 8'h3F, 1'h0);
    irqs(1'h0, 1'h0);
    // Return wins over a same-cycle clear of the global enable
    wr(ADDR_CTRL_BANK0, 8'h3F, 1'h1);
    rd(ADDR_CTRL_BANK1, 8'hBF);
    irqs(1'h1, 1'h0);
    for (int i = 0; i < 3; i++)
    begin
      wr(ADDR_CTRL_BANK0, 8'h80 | (8'h20 >> i) | (8'h04 >> i), 1'h0);
      irqs(1'h1, 1'h0);
      wr(ADDR_CTRL_BANK0, 8'h80 | (8'h20 >> i) | (8'h07 & ~(8'h04 >> i)), 1'h0);
      irqs(1'h0, 1'h0);
    end
    wr(ADDR_IRQ_MASK, 8'h07, 1'h0);
    irqs(1'h0, 1'h1);
    rd(ADDR_IRQ_STATUS, 8'h07);
    wr(ADDR_IRQ_STATUS, 8'h07, 1'h0);
    irqs(1'h0, 1'h0);
    wr(8'h55, 8'hFF, 1'h0);
    rd(8'h55, 8'h00);
    rd(ADDR_CTRL_BANK0, 8'h8E);
    // Events land in the same cycle as software clears
    fork
      wr(ADDR_IRQ_STATUS, 8'h07, 1'h0);
      pulse(3'h4);
    join
    rd(ADDR_IRQ_STATUS, 8'h04);
    fork
      wr(ADDR_CTRL_BANK0, 8'h80, 1'h0);
      pulse(3'h2);
    join
    rd(ADDR_CTRL_BANK0, 8'h82);
    // Second reset in mid-run
    @(posedge mclk);
    rst_b <= 1'h0;
    repeat (2) @(posedge mclk);
    rst_b <= 1'h1;
    rd(ADDR_CTRL_BANK1, CTRL_RESET);
    rd(ADDR_IRQ_MASK, 8'h00);
    irqs(1'h0, 1'h0);
    end_of_test();
  end
endmodule : tb

// ---- verilog/interrupt_control_pkg.sv ----
package irq_ctrl_pkg;
  // ---------------------------------------------
  // Addresses
  // ---------------------------------------------
  localparam logic [7:0] ADDR_CTRL_BANK0 = 8'h0B;
  localparam logic [7:0] ADDR_CTRL_BANK1 = 8'h8B;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h0D;
  // ---------------------------------------------
  // Field positions
  // ---------------------------------------------
  localparam int BIT_GLOBAL_EN = 7;
  localparam int BIT_UNUSED = 6;
  localparam int BIT_TMR_EN = 5;
  localparam int BIT_PIN_EN = 4;
  localparam int BIT_PORT_EN = 3;
  localparam int BIT_TMR_FLAG = 2;
  localparam int BIT_PIN_FLAG = 1;
  localparam int BIT_PORT_FLAG = 0;
  // ---------------------------------------------
  // Reset values and writable mask
  // ---------------------------------------------
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic PORT_FLAG_RESET = 1'h0;
  localparam logic [2:0] EVT_RESET = 3'h0;
  localparam logic [7:0] WRITABLE_MASK = 8'hBF;
endpackage : irq_ctrl_pkg

// ---- verilog/interrupt_enable_flag_register.sv ----
// Implementation choice: strobed register access.
`timescale 1ns/1ps
module interrupt_enable_flag_register
  import irq_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] addr,
  input wire logic [7:0] wrData,
  input wire logic wrStb,
  input wire logic rdStb,
  output logic [7:0] rdData_q,
  input wire logic timerOverflow,
  input wire logic extPinEdge,
  input wire logic portChange,
  input wire logic returnFromInterrupt,
  output logic coreIrq_q,
  output logic irq_q
);
  // ---------------------------------------------
  // Decode
  // ---------------------------------------------
  function automatic logic is_ctrl(input logic [7:0] a);
    return (a == ADDR_CTRL_BANK0) || (a == ADDR_CTRL_BANK1);
  endfunction : is_ctrl

  logic ctrlWr;
  logic statWr;
  logic maskWr;
  assign ctrlWr = wrStb && is_ctrl(addr);
  assign statWr = wrStb && (addr == ADDR_IRQ_STATUS);
  assign maskWr = wrStb && (addr == ADDR_IRQ_MASK);

  // ---------------------------------------------
  // Enable bits
  // ---------------------------------------------
  logic globalIrqEnable_q, globalIrqEnable_d;
  logic [2:0] en_q, en_d;

  always_comb
  begin
    globalIrqEnable_d = globalIrqEnable_q;
    en_d = en_q;
    if (ctrlWr)
    begin
      globalIrqEnable_d = wrData[BIT_GLOBAL_EN];
      en_d = wrData[BIT_TMR_EN:BIT_PORT_EN];
    end
    // Hardware return wins over a same-cycle write
    if (returnFromInterrupt)
      globalIrqEnable_d = 1'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      globalIrqEnable_q <= CTRL_RESET[BIT_GLOBAL_EN];
      en_q <= CTRL_RESET[BIT_TMR_EN:BIT_PORT_EN];
    end
    else
    begin
      globalIrqEnable_q <= globalIrqEnable_d;
      en_q <= en_d;
    end
  end

  // ---------------------------------------------
  // Flags
  // ---------------------------------------------
  logic tmrFlag, pinFlag, portFlag;

  sticky_flag u_tmr (
    .mclk(mclk), .rst_b(rst_b), .resetVal(CTRL_RESET[BIT_TMR_FLAG]),
    .setEvt(timerOverflow), .wrEn(ctrlWr), .wrVal(wrData[BIT_TMR_FLAG]),
    .flag_q(tmrFlag));
  sticky_flag u_pin (
    .mclk(mclk), .rst_b(rst_b), .resetVal(CTRL_RESET[BIT_PIN_FLAG]),
    .setEvt(extPinEdge), .wrEn(ctrlWr), .wrVal(wrData[BIT_PIN_FLAG]),
    .flag_q(pinFlag));
  // Unknown at power-on; a fixed value is kept for simulation
  sticky_flag u_port (
    .mclk(mclk), .rst_b(rst_b), .resetVal(PORT_FLAG_RESET),
    .setEvt(portChange), .wrEn(ctrlWr), .wrVal(wrData[BIT_PORT_FLAG]),
    .flag_q(portFlag));

  logic [7:0] ctrlView;
  assign ctrlView = {globalIrqEnable_q, 1'h0, en_q, tmrFlag, pinFlag, portFlag};

  // ---------------------------------------------
  // Event status and mask
  // ---------------------------------------------
  logic [2:0] evtStat_q, evtStat_d, evtMask_q, evtMask_d;
  logic [2:0] evtIn;
  assign evtIn = {timerOverflow, extPinEdge, portChange};

  always_comb
  begin
    evtMask_d = evtMask_q;
    if (maskWr)
      evtMask_d = wrData[2:0];
    // Write one clears; a new event in the same cycle wins
    evtStat_d = evtStat_q;
    if (statWr)
      evtStat_d = evtStat_q & ~wrData[2:0];
    evtStat_d = evtStat_d | evtIn;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      evtStat_q <= EVT_RESET;
      evtMask_q <= EVT_RESET;
    end
    else
    begin
      evtStat_q <= evtStat_d;
      evtMask_q <= evtMask_d;
    end
  end

  // ---------------------------------------------
  // Read port and outputs
  // ---------------------------------------------
  logic [7:0] rdData_d;
  logic coreIrq_d, irq_d;

  always_comb
  begin
    rdData_d = 8'h00;
    if (rdStb)
    begin
      if (is_ctrl(addr))
        rdData_d = ctrlView;
      else if (addr == ADDR_IRQ_STATUS)
        rdData_d = {5'h00, evtStat_q};
      else if (addr == ADDR_IRQ_MASK)
        rdData_d = {5'h00, evtMask_q};
    end
    coreIrq_d = globalIrqEnable_q && |(en_q & {tmrFlag, pinFlag, portFlag});
    irq_d = |(evtStat_d & evtMask_d);
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
    begin
      rdData_q <= 8'h00;
      coreIrq_q <= 1'h0;
      irq_q <= 1'h0;
    end
    else
    begin
      rdData_q <= rdData_d;
      coreIrq_q <= coreIrq_d;
      irq_q <= irq_d;
    end
  end

  // ---------------------------------------------
  // Checks
  // ---------------------------------------------
  a_bit6_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rdStb && is_ctrl(addr) |=> !rdData_q[BIT_UNUSED]
  )
  else $error("bit 6 not zero");

  a_banks_alias: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrStb && (addr == ADDR_CTRL_BANK1) |=> en_q == $past(wrData[BIT_TMR_EN:BIT_PORT_EN])
  )
  else $error("bank 1 write missed");

  a_bank0_alias: assert property (
    @(posedge mclk) disable iff (!rst_b)
    wrStb && (addr == ADDR_CTRL_BANK0) |=> en_q == $past(wrData[BIT_TMR_EN:BIT_PORT_EN])
  )
  else $error("bank 0 write missed");

  a_global_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ctrlWr && !returnFromInterrupt |=> globalIrqEnable_q == $past(wrData[BIT_GLOBAL_EN])
  )
  else $error("global enable write lost");

  a_return_enable: assert property (
    @(posedge mclk) disable iff (!rst_b)
    returnFromInterrupt |=> globalIrqEnable_q
  )
  else $error("global enable not set on return");

  a_global_blocks: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !globalIrqEnable_q |=> !coreIrq_q
  )
  else $error("request while global enable clear");

  a_global_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !ctrlWr && !returnFromInterrupt |=> $stable(globalIrqEnable_q)
  )
  else $error("global enable moved alone");

  a_timer_raise: assert property (
    @(posedge mclk) disable iff (!rst_b)
    globalIrqEnable_q && en_q[2] && tmrFlag |=> coreIrq_q
  )
  else $error("timer request missing");

  a_pin_raise: assert property (
    @(posedge mclk) disable iff (!rst_b)
    globalIrqEnable_q && en_q[1] && pinFlag |=> coreIrq_q
  )
  else $error("pin request missing");

  a_port_raise: assert property (
    @(posedge mclk) disable iff (!rst_b)
    globalIrqEnable_q && en_q[0] && portFlag |=> coreIrq_q
  )
  else $error("port request missing");

  a_irq_quiet: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !(|(en_q & {tmrFlag, pinFlag, portFlag})) |=> !coreIrq_q
  )
  else $error("request without enabled flag");

  a_flag_sticky: assert property (
    @(posedge mclk) disable iff (!rst_b)
    pinFlag && !ctrlWr |=> pinFlag
  )
  else $error("flag dropped");

  a_flag_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ctrlWr && !extPinEdge |=> pinFlag == $past(wrData[BIT_PIN_FLAG])
  )
  else $error("flag write lost");

  a_enable_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    ctrlWr |=> en_q == $past(wrData[BIT_TMR_EN:BIT_PORT_EN])
  )
  else $error("enable write lost");

  a_enable_hold: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !ctrlWr |=> $stable(en_q)
  )
  else $error("enables moved alone");

  a_timer_set: assert property (
    @(posedge mclk) disable iff (!rst_b)
    timerOverflow |=> tmrFlag && evtStat_q[2]
  )
  else $error("timer event lost");

  a_pin_set: assert property (
    @(posedge mclk) disable iff (!rst_b)
    extPinEdge |=> pinFlag && evtStat_q[1]
  )
  else $error("pin event lost");

  a_port_set: assert property (
    @(posedge mclk) disable iff (!rst_b)
    portChange |=> portFlag && evtStat_q[0]
  )
  else $error("port event lost");

  a_stat_clear: assert property (
    @(posedge mclk) disable iff (!rst_b)
    statWr && wrData[2] && !timerOverflow |=> !evtStat_q[2]
  )
  else $error("status clear lost");

  a_stat_setwins: assert property (
    @(posedge mclk) disable iff (!rst_b)
    statWr && wrData[2] && timerOverflow |=> evtStat_q[2]
  )
  else $error("status clear beat event");

  a_stat_sticky: assert property (
    @(posedge mclk) disable iff (!rst_b)
    evtStat_q[1] && !statWr |=> evtStat_q[1]
  )
  else $error("status bit dropped");

  a_mask_write: assert property (
    @(posedge mclk) disable iff (!rst_b)
    maskWr |=> evtMask_q == $past(wrData[2:0])
  )
  else $error("mask write lost");

  a_irq_level: assert property (
    @(posedge mclk) disable iff (!rst_b)
    irq_q == |(evtStat_q & evtMask_q)
  )
  else $error("event request level wrong");

  a_read_idle: assert property (
    @(posedge mclk) disable iff (!rst_b)
    !rdStb |=> rdData_q == 8'h00
  )
  else $error("read data outside read");

  a_read_ctrl: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rdStb && is_ctrl(addr) |=> rdData_q == $past(ctrlView)
  )
  else $error("control read wrong");

  a_unmapped_zero: assert property (
    @(posedge mclk) disable iff (!rst_b)
    rdStb && !is_ctrl(addr) && (addr[7:1] != ADDR_IRQ_STATUS[7:1]) |=> rdData_q == 8'h00
  )
  else $error("unmapped read not zero");

  a_reset_clear: assert property (
    @(posedge mclk)
    !rst_b |=> rdData_q == 8'h00 && !globalIrqEnable_q && en_q == 3'h0
  )
  else $error("reset value");
endmodule : interrupt_enable_flag_register

// ---- verilog/sticky_flag.sv ----
`timescale 1ns/1ps
module sticky_flag
  import irq_ctrl_pkg::*;
(
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic resetVal,
  input wire logic setEvt,
  input wire logic wrEn,
  input wire logic wrVal,
  output logic flag_q
);
  logic flag_d;

  always_comb
  begin
    flag_d = flag_q;
    if (wrEn)
      flag_d = wrVal;
    // Event beats a same-cycle software clear
    if (setEvt)
      flag_d = 1'h1;
  end

  always_ff @(posedge mclk)
  begin
    if (!rst_b)
      flag_q <= resetVal;
    else
      flag_q <= flag_d;
  end

  a_set_wins: assert property (@(posedge mclk) disable iff (!rst_b)
    setEvt |=> flag_q) else $error("flag not set after event");
endmodule : sticky_flag
